//--- common/wes_pkg.sv
// Constants, register map and carrier types for the wake event status bank.
// Assumes a 20 MHz ref_clk and an APB master with 32-bit data.
//
// Contract
// - Each status flag is sticky: hardware sets it, only software write-one clears, except the legacy hardware clear of the power-button flag.
// - Register at index one holds group status bits 8 to 15.
// - Register at index two holds group status bits 16 to 23.
// - First register bits 7..0 latch active levels on port pins 7..0.
// - Port pin events pass polarity select and optional debounce before setting flags.
// - Write one clears a flag, write zero keeps it; all flags reset to zero.
// - Second register bit 7 sets on a debounced power-button press.
// - Clearing the power-button flag also clears the PM1 power-button flag.
// - Legacy setting and button power-off make hardware clear the power-button flag.
// - Second register bit 6 sets on a debounced sleep-button press.
// - Clearing the sleep-button flag also clears the PM1 sleep-button flag.
// - Bit 5 sets on management key 3, only in management key mode.
// - Bit 4 sets on management key 2, only in management key mode.
// - Bit 3 sets on any keyboard event identified by the wake-up detector.
// - Bit 2 sets when the wake-up detector identifies a mouse event.
// - Bits 1 and 0 set on falling ring-indicator edges of ports 2 and 1.
package wes_pkg;

  // APB geometry
  localparam int          APB_AW       = 12;
  localparam int          APB_DW       = 32;

  // Register indices; the byte address is four times the index
  localparam logic [9:0]  PORT_STS_IDX = 10'h001;
  localparam logic [9:0]  BTN_STS_IDX  = 10'h002;
  localparam logic [9:0]  PORT_POL_IDX = 10'h004;
  localparam logic [9:0]  PORT_DBN_IDX = 10'h005;
  localparam logic [9:0]  CTRL_IDX     = 10'h006;

  // Reset values
  localparam logic [7:0]  STS_RESET    = 8'h00;
  localparam logic [7:0]  POL_RESET    = 8'h00;
  localparam logic [7:0]  DBN_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;

  // Fields of the button register
  localparam int          BTN_PWR      = 7;
  localparam int          BTN_SLP      = 6;
  localparam int          BTN_KEY3     = 5;
  localparam int          BTN_KEY2     = 4;
  localparam int          BTN_KEY1     = 3;
  localparam int          BTN_MOUSE    = 2;
  localparam int          BTN_RING2    = 1;
  localparam int          BTN_RING1    = 0;

  // Field of the control register
  localparam int          CTRL_LEGACY  = 0;

  // Debounce timing
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          DEBOUNCE_NS   = 16000;
  localparam int          DEBOUNCE_CYC  = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
    logic [3:0]        pstrb;
  } wes_apb_req_t;

  typedef struct packed {
    logic pm_key_mode;
    logic key3_evt;
    logic key2_evt;
    logic key1_evt;
    logic mouse_evt;
  } wes_kbd_evt_t;

endpackage : wes_pkg

//--- logic/wes_debounce.sv
// Level debouncer: output follows input once it has stood still long enough.
// Assumes the input is already synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module wes_debounce #(
  parameter int CYCLES = 320
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Level in and out
  input  wire logic enable,
  input  wire logic raw,
  output var  logic stable_q
);

  localparam int CW = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_chk
    $error("wes_debounce: CYCLES must be at least one");
  end

  logic [CW-1:0] cnt_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q    <= '0;
      stable_q <= 1'b0;
    end else if (raw == stable_q) begin
      cnt_q <= '0;
    end else if (!enable || cnt_q == CW'(CYCLES - 1)) begin
      cnt_q    <= '0;
      stable_q <= raw;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

endmodule : wes_debounce
`default_nettype wire

//--- logic/wes_bank.sv
// Wake event status bank: two sticky write-one-to-clear status registers
// and their APB slave, polarity and debounce configuration.
// Assumes all event inputs are synchronous to ref_clk; APB zero-wait-state
// answers come one cycle after the setup cycle.
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module wes_bank
  import wes_pkg::*;
#(
  parameter int PORT_W   = 8,
  parameter int DBN_CYC  = DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // APB slave
  input  wire wes_apb_req_t      apb_req,
  output var  logic [APB_DW-1:0] prdata_q,
  output var  logic              pready_q,
  output var  logic              pslverr_q,
  // Event port pins
  input  wire logic [PORT_W-1:0] port_pins,
  // Buttons, active low while pressed; button power-off is active high
  input  wire logic              power_button_input_n,
  input  wire logic              sleep_button_input_n,
  input  wire logic              button_power_off,
  // Keyboard and mouse wake-up detector
  input  wire wes_kbd_evt_t      kbd_evt,
  // Ring indicators
  input  wire logic              ring_indicator_port1,
  input  wire logic              ring_indicator_port2,
  // PM1 status high clear strobes
  output var  logic              pm1_power_button_clr_q,
  output var  logic              pm1_sleep_button_clr_q,
  // Any flag set
  output var  logic              wake_pending_q
);

  if (PORT_W != 8) begin : g_chk
    $error("wes_bank: PORT_W must be 8 to fit one status register");
  end

  // Status and configuration registers
  logic [7:0] port_sts_q;
  logic [7:0] btn_sts_q;
  logic [7:0] port_pol_q;
  logic [7:0] port_dbn_q;
  logic [7:0] ctrl_q;
  logic [7:0] port_sts_d;
  logic [7:0] btn_sts_d;

  // APB decode
  logic       setup_w;
  logic       wr_fire_w;
  logic       addr_ok_w;
  logic [9:0] idx_w;
  logic       hit_port_w;
  logic       hit_btn_w;
  logic       hit_pol_w;
  logic       hit_dbn_w;
  logic       hit_ctrl_w;
  logic [7:0] wbyte_w;
  logic [7:0] port_clr_w;
  logic [7:0] btn_clr_w;

  // Event conditioning
  logic [7:0] pin_active_w;
  logic [7:0] port_set_w;
  logic [7:0] btn_set_w;
  logic       pwr_dbn_w;
  logic       slp_dbn_w;
  logic       pwr_dbn_q;
  logic       slp_dbn_q;
  logic       ring1_q;
  logic       ring2_q;
  logic       pwr_press_w;
  logic       slp_press_w;
  logic       ring1_fall_w;
  logic       ring2_fall_w;
  logic       legacy_clr_w;

  assign idx_w      = apb_req.paddr[APB_AW-1:2];
  assign addr_ok_w  = apb_req.paddr[1:0] == 2'b00;
  assign hit_port_w = addr_ok_w && idx_w == PORT_STS_IDX;
  assign hit_btn_w  = addr_ok_w && idx_w == BTN_STS_IDX;
  assign hit_pol_w  = addr_ok_w && idx_w == PORT_POL_IDX;
  assign hit_dbn_w  = addr_ok_w && idx_w == PORT_DBN_IDX;
  assign hit_ctrl_w = addr_ok_w && idx_w == CTRL_IDX;

  assign setup_w    = apb_req.psel && !apb_req.penable;
  // A write lands at the access edge where pready is sampled high
  assign wr_fire_w  = apb_req.psel && apb_req.penable && pready_q && apb_req.pwrite && apb_req.pstrb[0];
  assign wbyte_w    = apb_req.pwdata[7:0];

  // Write one clears, write zero is ignored
  assign port_clr_w = (wr_fire_w && hit_port_w) ? wbyte_w : 8'h00;
  assign btn_clr_w  = (wr_fire_w && hit_btn_w) ? wbyte_w : 8'h00;

  // Pin events: polarity first, then optional debounce
  assign pin_active_w = port_pins ^ port_pol_q;

  for (genvar i = 0; i < PORT_W; i++) begin : g_pin
    wes_debounce #(
      .CYCLES (DBN_CYC)
    ) u_pin_dbn (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .enable   (port_dbn_q[i]),
      .raw      (pin_active_w[i]),
      .stable_q (port_set_w[i])
    );
  end

  // Buttons always debounced
  wes_debounce #(
    .CYCLES (DBN_CYC)
  ) u_pwr_dbn (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .enable   (1'b1),
    .raw      (!power_button_input_n),
    .stable_q (pwr_dbn_w)
  );

  wes_debounce #(
    .CYCLES (DBN_CYC)
  ) u_slp_dbn (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .enable   (1'b1),
    .raw      (!sleep_button_input_n),
    .stable_q (slp_dbn_w)
  );

  // Edge history for buttons and ring indicators
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_dbn_q <= 1'b0;
      slp_dbn_q <= 1'b0;
      ring1_q   <= 1'b1;
      ring2_q   <= 1'b1;
    end else begin
      pwr_dbn_q <= pwr_dbn_w;
      slp_dbn_q <= slp_dbn_w;
      ring1_q   <= ring_indicator_port1;
      ring2_q   <= ring_indicator_port2;
    end
  end

  // A held button sets its flag once per press, so a cleared flag stays clear
  assign pwr_press_w  = pwr_dbn_w && !pwr_dbn_q;
  assign slp_press_w  = slp_dbn_w && !slp_dbn_q;
  assign ring1_fall_w = ring1_q && !ring_indicator_port1;
  assign ring2_fall_w = ring2_q && !ring_indicator_port2;
  assign legacy_clr_w = ctrl_q[CTRL_LEGACY] && button_power_off;

  always_comb begin
    btn_set_w            = 8'h00;
    btn_set_w[BTN_PWR]   = pwr_press_w;
    btn_set_w[BTN_SLP]   = slp_press_w;
    btn_set_w[BTN_KEY3]  = kbd_evt.pm_key_mode && kbd_evt.key3_evt;
    btn_set_w[BTN_KEY2]  = kbd_evt.pm_key_mode && kbd_evt.key2_evt;
    btn_set_w[BTN_KEY1]  = kbd_evt.key1_evt;
    btn_set_w[BTN_MOUSE] = kbd_evt.mouse_evt;
    btn_set_w[BTN_RING2] = ring2_fall_w;
    btn_set_w[BTN_RING1] = ring1_fall_w;
  end

  // Sticky flags; a set beats a software clear in the same cycle
  always_comb begin
    port_sts_d = (port_sts_q & ~port_clr_w) | port_set_w;
    btn_sts_d  = (btn_sts_q & ~btn_clr_w) | btn_set_w;
    if (legacy_clr_w) begin
      btn_sts_d[BTN_PWR] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_sts_q <= STS_RESET;
      btn_sts_q  <= STS_RESET;
    end else begin
      port_sts_q <= port_sts_d;
      btn_sts_q  <= btn_sts_d;
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_pol_q <= POL_RESET;
      port_dbn_q <= DBN_RESET;
      ctrl_q     <= CTRL_RESET;
    end else if (wr_fire_w) begin
      if (hit_pol_w) begin
        port_pol_q <= wbyte_w;
      end
      if (hit_dbn_w) begin
        port_dbn_q <= wbyte_w;
      end
      if (hit_ctrl_w) begin
        ctrl_q <= {7'h00, wbyte_w[CTRL_LEGACY]};
      end
    end
  end

  // Companion PM1 flags clear in the same write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pm1_power_button_clr_q <= 1'b0;
      pm1_sleep_button_clr_q <= 1'b0;
    end else begin
      pm1_power_button_clr_q <= btn_clr_w[BTN_PWR];
      pm1_sleep_button_clr_q <= btn_clr_w[BTN_SLP];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_pending_q <= 1'b0;
    end else begin
      wake_pending_q <= |{port_sts_d, btn_sts_d};
    end
  end

  // APB answer: captured in the setup cycle, presented in the access cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else if (setup_w) begin
      pready_q  <= 1'b1;
      pslverr_q <= !(hit_port_w || hit_btn_w || hit_pol_w || hit_dbn_w || hit_ctrl_w);
      prdata_q  <= '0;
      if (!apb_req.pwrite) begin
        unique case (1'b1)
          hit_port_w: prdata_q <= {24'h000000, port_sts_q};
          hit_btn_w:  prdata_q <= {24'h000000, btn_sts_q};
          hit_pol_w:  prdata_q <= {24'h000000, port_pol_q};
          hit_dbn_w:  prdata_q <= {24'h000000, port_dbn_q};
          hit_ctrl_w: prdata_q <= {24'h000000, ctrl_q};
          default:    prdata_q <= '0;
        endcase
      end
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sticky_hold_a:
    assert property ((btn_sts_q[BTN_KEY1] && btn_clr_w[BTN_KEY1] == 1'b0) |=> btn_sts_q[BTN_KEY1])
    else $error("key1 flag dropped without a clear");

  port_set_a:
    assert property (1'b1 |=> (port_sts_q & $past(port_set_w)) == $past(port_set_w))
    else $error("port pin event did not set its flag");

  port_polarity_a:
    assert property ($rose(port_sts_q[0]) && !port_dbn_q[0] |-> $past(port_pins[0] ^ port_pol_q[0], 2))
    else $error("port flag set without an active level");

  w1c_clear_a:
    assert property (1'b1 |=> (port_sts_q & $past(port_clr_w) & ~$past(port_set_w)) == 8'h00)
    else $error("write one failed to clear a port flag");

  // Power flag left out: it also has a hardware clear
  write_zero_keeps_a:
    assert property ((wr_fire_w && hit_btn_w)
                     |=> ((btn_sts_q | ~$past(btn_sts_q) | $past(wbyte_w)) & 8'h7f) == 8'h7f)
    else $error("write zero changed a flag");

  set_wins_a:
    assert property ((btn_clr_w[BTN_KEY1] && btn_set_w[BTN_KEY1]) |=> btn_sts_q[BTN_KEY1])
    else $error("set lost against a same-cycle clear");

  pwr_press_a:
    assert property ($rose(btn_sts_q[BTN_PWR]) |-> $past(pwr_dbn_w) && !$past(pwr_dbn_q))
    else $error("power flag set without a debounced press");

  slp_press_a:
    assert property ($rose(btn_sts_q[BTN_SLP]) |-> $past(slp_dbn_w) && !$past(slp_dbn_q))
    else $error("sleep flag set without a debounced press");

  pm1_pwr_clr_a:
    assert property ((wr_fire_w && hit_btn_w && wbyte_w[BTN_PWR]) |=> pm1_power_button_clr_q ##1 !pm1_power_button_clr_q)
    else $error("PM1 power flag clear strobe missing");

  pm1_slp_clr_a:
    assert property ((wr_fire_w && hit_btn_w && wbyte_w[BTN_SLP])
                     |=> pm1_sleep_button_clr_q ##1 !pm1_sleep_button_clr_q)
    else $error("PM1 sleep flag clear strobe missing");

  legacy_clear_a:
    assert property ((ctrl_q[CTRL_LEGACY] && button_power_off) |=> !btn_sts_q[BTN_PWR])
    else $error("legacy power-off did not clear power flag");

  key_mode_a:
    assert property ($rose(btn_sts_q[BTN_KEY3]) || $rose(btn_sts_q[BTN_KEY2]) |-> $past(kbd_evt.pm_key_mode))
    else $error("management key flag set outside key mode");

  ring_edge_a:
    assert property ($rose(btn_sts_q[BTN_RING2]) |-> $past(ring2_q) && !$past(ring_indicator_port2))
    else $error("ring flag set without a falling edge");

  read_port_a:
    assert property ((setup_w && !apb_req.pwrite && hit_port_w) |=> pready_q && prdata_q[7:0] == $past(port_sts_q))
    else $error("index one read returned wrong data");

  read_btn_a:
    assert property ((setup_w && !apb_req.pwrite && hit_btn_w) |=> pready_q && prdata_q == {24'h000000, $past(btn_sts_q)})
    else $error("index two read returned wrong data");

  port_sticky_a:
    assert property (1'b1 |=> (port_sts_q & $past(port_sts_q) & ~$past(port_clr_w))
                              == ($past(port_sts_q) & ~$past(port_clr_w)))
    else $error("port flag dropped without a clear");

  pwr_set_a:
    assert property ((pwr_press_w && !legacy_clr_w) |=> btn_sts_q[BTN_PWR])
    else $error("power press did not set its flag");

  slp_set_a:
    assert property (slp_press_w |=> btn_sts_q[BTN_SLP])
    else $error("sleep press did not set its flag");

  key3_set_a:
    assert property ((kbd_evt.pm_key_mode && kbd_evt.key3_evt) |=> btn_sts_q[BTN_KEY3])
    else $error("management key 3 did not set its flag");

  key2_set_a:
    assert property ((kbd_evt.pm_key_mode && kbd_evt.key2_evt) |=> btn_sts_q[BTN_KEY2])
    else $error("management key 2 did not set its flag");

  key1_set_a:
    assert property (kbd_evt.key1_evt |=> btn_sts_q[BTN_KEY1])
    else $error("keyboard event did not set its flag");

  mouse_set_a:
    assert property (kbd_evt.mouse_evt |=> btn_sts_q[BTN_MOUSE])
    else $error("mouse event did not set its flag");

  ring1_edge_a:
    assert property ($rose(btn_sts_q[BTN_RING1]) |-> $past(ring1_q) && !$past(ring_indicator_port1))
    else $error("ring one flag set without a falling edge");

endmodule : wes_bank
`default_nettype wire

//--- verification/wes_bank_tb.sv
// Self-checking testbench for the wake event status bank.
// Assumes wes_pkg and the bank are compiled first; the bench drives every port itself.
`timescale 1ns/1ns
`default_nettype none
module wes_bank_tb
  import wes_pkg::*;
;
  localparam int DBN = 4;
  logic              ref_clk;
  logic              rst_n;
  wes_apb_req_t      req;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              pwr_clr;
  logic              slp_clr;
  logic              wake;
  logic [7:0]        pins;
  logic              pwr_n;
  logic              slp_n;
  logic              pwr_off;
  logic              ring1;
  logic              ring2;
  wes_kbd_evt_t      kbd;
  logic              key1_on_access;
  int                error_cnt;
  int                check_count;
  logic [31:0]       d;
  logic              e;

  wes_bank #(.DBN_CYC(DBN)) wes_bank_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .apb_req(req), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .port_pins(pins), .power_button_input_n(pwr_n), .sleep_button_input_n(slp_n),
    .button_power_off(pwr_off), .kbd_evt(kbd), .ring_indicator_port1(ring1), .ring_indicator_port2(ring2),
    .pm1_power_button_clr_q(pwr_clr), .pm1_sleep_button_clr_q(slp_clr), .wake_pending_q(wake));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One APB transfer; optionally pulses key1 so it lands on the write edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge ref_clk);
    req.penable <= 1'b1;
    if (key1_on_access) kbd.key1_evt <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready_q !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1, "no pready");
    d = prdata_q;
    e = pslverr_q;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (key1_on_access) kbd.key1_evt <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(d, exp, what);
    chk({31'h0, e}, 32'h0, "read err");
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
    chk({31'h0, e}, 32'h0, "write err");
  endtask : wr

  task automatic t_reset;
    rd(12'h004, 32'h0, "port reset");
    rd(12'h008, 32'h0, "button reset");
    chk({31'h0, wake}, 32'h0, "pending reset");
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped err");
    chk(d, 32'h0, "unmapped data");
    apb(1'b0, 12'h005, 32'h0);
    chk({31'h0, e}, 32'h1, "misaligned err");
  endtask : t_reset

  task automatic t_port;
    pins <= 8'h81;
    cyc(2);
    pins <= 8'h00;
    cyc(3);
    rd(12'h004, 32'h81, "port sticky");
    chk({31'h0, wake}, 32'h1, "pending set");
    wr(12'h004, 32'h01);
    rd(12'h004, 32'h80, "port w1c");
    wr(12'h004, 32'h00);
    rd(12'h004, 32'h80, "port w0");
    wr(12'h004, 32'h80);
    wr(12'h010, 32'h02);
    cyc(3);
    wr(12'h010, 32'h00);
    rd(12'h004, 32'h02, "polarity");
    wr(12'h004, 32'h02);
    wr(12'h014, 32'h04);
    pins <= 8'h04;
    cyc(2);
    pins <= 8'h00;
    cyc(8);
    rd(12'h004, 32'h0, "glitch filtered");
    pins <= 8'h04;
    cyc(12);
    pins <= 8'h00;
    cyc(3);
    rd(12'h004, 32'h04, "debounced");
    wr(12'h004, 32'h04);
    wr(12'h014, 32'h00);
  endtask : t_port

  task automatic btn(input int b);
    if (b == 7) pwr_n <= 1'b0;
    else slp_n <= 1'b0;
    cyc(12);
    pwr_n <= 1'b1;
    slp_n <= 1'b1;
    cyc(12);
    rd(12'h008, 32'h1 << b, "button set");
  endtask : btn

  // Clear a button flag and watch the companion clear strobe
  task automatic clr_btn(input int b);
    apb(1'b1, 12'h008, 32'h1 << b);
    #1;
    chk({30'h0, pwr_clr, slp_clr}, {30'h0, b == 7, b == 6}, "pm1 strobe");
    @(posedge ref_clk);
    #1;
    chk({30'h0, pwr_clr, slp_clr}, 32'h0, "pm1 strobe end");
    rd(12'h008, 32'h0, "button clr");
  endtask : clr_btn

  task automatic t_button;
    btn(7);
    pwr_off <= 1'b1;
    cyc(1);
    pwr_off <= 1'b0;
    cyc(2);
    rd(12'h008, 32'h80, "no legacy");
    clr_btn(7);
    btn(6);
    clr_btn(6);
    wr(12'h018, 32'h01);
    btn(7);
    pwr_off <= 1'b1;
    cyc(1);
    pwr_off <= 1'b0;
    cyc(2);
    rd(12'h008, 32'h0, "legacy clr");
    wr(12'h018, 32'h00);
  endtask : t_button

  task automatic kev(input logic [4:0] ev, input logic [31:0] exp);
    kbd <= wes_kbd_evt_t'(ev);
    cyc(1);
    kbd <= wes_kbd_evt_t'(ev & 5'b10000);
    cyc(2);
    rd(12'h008, exp, "keyboard");
    wr(12'h008, exp);
  endtask : kev

  task automatic ring(input int b);
    if (b == 0) ring1 <= 1'b0;
    else ring2 <= 1'b0;
    cyc(2);
    ring1 <= 1'b1;
    ring2 <= 1'b1;
    cyc(2);
    rd(12'h008, 32'h1 << b, "ring");
    wr(12'h008, 32'h1 << b);
  endtask : ring

  task automatic t_race;
    kbd <= wes_kbd_evt_t'(5'b00010);
    cyc(1);
    kbd <= wes_kbd_evt_t'(5'b00000);
    cyc(2);
    wr(12'h008, 32'h00);
    rd(12'h008, 32'h08, "button w0");
    key1_on_access = 1'b1;
    wr(12'h008, 32'h08);
    key1_on_access = 1'b0;
    rd(12'h008, 32'h08, "set beats clear");
    wr(12'h008, 32'h08);
    rd(12'h008, 32'h0, "all clear");
    cyc(2);
    chk({31'h0, wake}, 32'h0, "pending clear");
  endtask : t_race

  // Byte strobe off ignores a write; a mid-run reset clears set flags
  task automatic t_midreset;
    pins <= 8'h10;
    cyc(2);
    pins <= 8'h00;
    cyc(2);
    req.pstrb <= 4'he;
    cyc(1);
    wr(12'h004, 32'h10);
    cyc(1);
    req.pstrb <= 4'hf;
    rd(12'h004, 32'h10, "strobe off keeps");
    rst_n <= 1'b0;
    cyc(3);
    rst_n <= 1'b1;
    rd(12'h004, 32'h0, "port after reset");
    chk({31'h0, wake}, 32'h0, "pending after reset");
  endtask : t_midreset

  task automatic report_and_stop;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  initial begin
    rst_n = 1'b0;
    req = '0;
    req.pstrb = 4'hf;
    pins = 8'h00;
    pwr_n = 1'b1;
    slp_n = 1'b1;
    pwr_off = 1'b0;
    ring1 = 1'b1;
    ring2 = 1'b1;
    kbd = '0;
    key1_on_access = 1'b0;
    error_cnt = 0;
    check_count = 0;
    cyc(3);
    rst_n <= 1'b1;
    t_reset;
    t_port;
    t_button;
    kev(5'b01100, 32'h00);
    kev(5'b11000, 32'h20);
    kev(5'b10100, 32'h10);
    kev(5'b00010, 32'h08);
    kev(5'b00001, 32'h04);
    ring(0);
    ring(1);
    t_race;
    t_midreset;
    report_and_stop;
  end

  // Cuts a hang short well beyond the expected run length
  initial begin
    cyc(5000);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop;
  end
endmodule : wes_bank_tb
`default_nettype wire
